// ===== include/can_fc_map.svh
`ifndef CAN_FC_MAP_SVH
`define CAN_FC_MAP_SVH
// ==========================================================
// Register offsets, per channel
`define FC_TX_CONTROL_CH0 16'hFF22
`define FC_RX_NEW_MESSAGE_CH0 16'hFF23
`define FC_ID_FILTER_CONTROL_CH0 16'hFF2C
`define FC_TX_CONTROL_CH1 16'hFD22
`define FC_RX_NEW_MESSAGE_CH1 16'hFD23
`define FC_ID_FILTER_CONTROL_CH1 16'hFD2C
// ==========================================================
// Reset values, and the value read at unmapped addresses
`define FC_TX_CONTROL_RESET 8'h00
`define FC_RX_NEW_MESSAGE_RESET 8'h00
`define FC_ID_FILTER_CONTROL_RESET 8'h00
`define FC_UNMAPPED_READ 8'h00
// ==========================================================
// Transmit control fields
`define FC_TX_REQ_LSB 0
`define FC_TX_ABORT_LSB 2
`define FC_TX_DONE_LSB 4
`define FC_TX_PRIO_BIT 7
// ==========================================================
// Identifier filter control fields
`define FC_MASK_ZERO_BIT 0
`define FC_MASK_ONE_BIT 1
`define FC_GLOBAL_MASK_BIT 2
`define FC_REQUEUE_BIT 4
`define FC_SINGLE_SHOT_BIT 5
`define FC_FILTER_WRITABLE 8'hF7
// ==========================================================
// Receive buffers
`define FC_MIRRORED_BUFFERS 8
`define FC_SOF_BUFFER 4'h4
`endif

// ===== include/can_fc_pkg.sv
package can_fc_pkg;
    // Transmit sequencer, one-hot
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_BUSY = 2'b10
    } tx_state_t;

    typedef logic [3:0] buf_idx_t;

    // Start-slot pulse and outcome pulses for the frame in flight, from the protocol engine
    typedef struct packed {
        logic start_slot;
        logic ok;
        logic arb_lost;
        logic err;
    } tx_event_t;

    // Filter roles handed to the identifier comparators
    typedef struct packed {
        logic [15:0] mask_role;
        logic [15:0] use_mask0;
        logic [15:0] use_mask1;
    } filter_roles_t;

    typedef struct packed {
        tx_state_t tx_state;
        logic [1:0] req;
        logic [1:0] abort;
        logic [1:0] done;
        logic prio;
        logic active_buf;
        logic [1:0] requeued;
        logic [7:0] mirror;
        logic [7:0] filter;
        logic [2:0] rx_sync;
        logic rx_level;
        logic [2:0] rx_hist;
        logic rx_bit;
        logic rx_bit_valid;
        logic can_txd;
        logic ack_enable;
        logic error_frame_enable;
        logic err_count_enable;
        logic tx_start;
        logic tx_buf;
        logic sof_enable_clear;
        logic [7:0] reg_rdata;
        filter_roles_t roles;
        buf_idx_t [1:0] fifo_mem;
        logic fifo_wr;
        logic fifo_rd;
        logic [1:0] fifo_count;
        logic match_ready;
        logic store_valid;
        buf_idx_t store_idx;
    } fc_state_t;
endpackage

// ===== core/can_tx_rx_function_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_fc_map.svh"

module can_tx_rx_function_control #(
    parameter bit CHANNEL = 1'b0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic init_request,
    input wire logic listen_only_select,
    input wire logic triple_sample_select,
    input wire logic frame_start_clear_control,
    input wire logic sof_mode,
    input wire logic can_rxd,
    input wire logic tq_tick,
    input wire logic sample_point,
    input wire logic proto_tx_bit,
    input wire can_fc_pkg::tx_event_t tx_event,
    input wire logic rx_store_done,
    input wire can_fc_pkg::buf_idx_t rx_store_idx,
    input wire logic [7:0] new_data_clear,
    input wire logic match_valid,
    input wire logic [15:0] match_vec,
    input wire logic store_ready,
    output logic match_ready,
    output logic store_valid,
    output can_fc_pkg::buf_idx_t store_idx,
    output logic can_txd,
    output logic ack_enable,
    output logic error_frame_enable,
    output logic err_count_enable,
    output logic tx_start,
    output logic tx_buf,
    output logic sof_enable_clear,
    output logic rx_bit,
    output logic rx_bit_valid,
    output can_fc_pkg::filter_roles_t filter_roles
);
    import can_fc_pkg::*;

    localparam logic [15:0] TX_ADDR = CHANNEL ? `FC_TX_CONTROL_CH1 : `FC_TX_CONTROL_CH0;
    localparam logic [15:0] MES_ADDR = CHANNEL ? `FC_RX_NEW_MESSAGE_CH1 : `FC_RX_NEW_MESSAGE_CH0;
    localparam logic [15:0] FLT_ADDR =
        CHANNEL ? `FC_ID_FILTER_CONTROL_CH1 : `FC_ID_FILTER_CONTROL_CH0;

    fc_state_t s;
    fc_state_t next_s;

    // ==========================================================
    // Helpers
    // Filter roles from the control byte; global mask spreads the highest mask upward
    function automatic filter_roles_t roles_of(input logic [7:0] f);
        filter_roles_t r;
        r = '0;
        if (f[`FC_MASK_ZERO_BIT])
        begin
            r.mask_role[0] = 1'b1;
            r.use_mask0[1] = 1'b1;
        end
        if (f[`FC_MASK_ONE_BIT])
        begin
            r.mask_role[2] = 1'b1;
            r.use_mask1[3] = 1'b1;
        end
        if (f[`FC_GLOBAL_MASK_BIT])
        begin
            if (f[`FC_MASK_ONE_BIT])
                r.use_mask1[15:3] = '1;
            else if (f[`FC_MASK_ZERO_BIT])
                r.use_mask0[15:1] = '1;
        end
        return r;
    endfunction

    // Lowest set bit of a vector, as an index
    function automatic buf_idx_t lowest(input logic [15:0] v);
        buf_idx_t idx;
        idx = '0;
        for (int i = 15; i >= 0; i--)
        begin
            if (v[i])
                idx = buf_idx_t'(i);
        end
        return idx;
    endfunction

    // Winner among matching buffers: unmasked first, then masked ones
    function automatic buf_idx_t winner(input logic [15:0] m, input filter_roles_t r);
        logic [15:0] eligible;
        logic [15:0] plain;
        eligible = m & ~r.mask_role;
        plain = eligible & ~(r.use_mask0 | r.use_mask1);
        return (plain != '0) ? lowest(plain) : lowest(eligible);
    endfunction

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        logic [1:0] wr_req;
        logic [1:0] wr_abort;
        logic [1:0] clr;
        logic [7:0] mirror_set;
        logic single_shot;
        logic requeue;
        logic [15:0] eligible;
        logic push;
        logic pop;
        logic a;
        next_s = s;
        wr_req = '0;
        wr_abort = '0;
        clr = '0;
        mirror_set = '0;
        single_shot = s.filter[`FC_SINGLE_SHOT_BIT];
        requeue = s.filter[`FC_REQUEUE_BIT];
        a = s.active_buf;
        next_s.tx_start = 1'b0;
        next_s.sof_enable_clear = 1'b0;
        next_s.rx_bit_valid = 1'b0;

        // Register writes; zeros in request and abort lanes change nothing
        if (reg_wr && reg_addr == TX_ADDR)
        begin
            wr_req = reg_wdata[`FC_TX_REQ_LSB +: 2];
            wr_abort = reg_wdata[`FC_TX_ABORT_LSB +: 2];
            next_s.prio = reg_wdata[`FC_TX_PRIO_BIT];
        end
        if (reg_wr && reg_addr == FLT_ADDR)
            next_s.filter = reg_wdata & `FC_FILTER_WRITABLE;

        // Transmit sequencer
        case (s.tx_state)
            TX_IDLE:
            begin
                // Abort before arbitration: drop the request, nothing was sent
                for (int b = 0; b < 2; b++)
                begin
                    if (s.abort[b])
                    begin
                        clr[b] = 1'b1;
                        next_s.done[b] = 1'b0;
                    end
                end
                // Requests are looked at only at the frame start slot
                if (tx_event.start_slot && !listen_only_select && (s.req & ~clr) != 2'b00)
                begin
                    next_s.tx_state = TX_BUSY;
                    next_s.tx_start = 1'b1;
                    if ((s.req & ~clr) == 2'b11)
                        next_s.active_buf = s.prio;
                    else
                        next_s.active_buf = s.req[1] & ~clr[1];
                    next_s.tx_buf = next_s.active_buf;
                end
            end
            TX_BUSY:
            begin
                // An abort waits here for the frame's own outcome
                if (tx_event.ok)
                begin
                    clr[a] = 1'b1;
                    next_s.done[a] = 1'b1;
                    next_s.tx_state = TX_IDLE;
                end
                else if (tx_event.arb_lost)
                begin
                    if (s.abort[a] || (single_shot && !(requeue && !s.requeued[a])))
                    begin
                        clr[a] = 1'b1;
                        next_s.done[a] = 1'b0;
                    end
                    else if (single_shot)
                        next_s.requeued[a] = 1'b1;
                    next_s.tx_state = TX_IDLE;
                end
                else if (tx_event.err)
                begin
                    // Error keeps the request for an automatic retry unless aborted or single-shot
                    if (s.abort[a] || single_shot)
                    begin
                        clr[a] = 1'b1;
                        next_s.done[a] = 1'b0;
                    end
                    next_s.tx_state = TX_IDLE;
                end
            end
            default:
                next_s.tx_state = TX_IDLE;
        endcase

        // Done flags only move in the cycle their request clears
        for (int b = 0; b < 2; b++)
        begin
            if (!(clr[b] && s.req[b]))
                next_s.done[b] = s.done[b];
        end

        // Clears first, then software sets, so a write in the same cycle wins
        next_s.req = (s.req & ~clr) | wr_req;
        next_s.abort = ((s.abort & ~clr) | wr_abort) & next_s.req;
        for (int b = 0; b < 2; b++)
        begin
            if (clr[b])
                next_s.requeued[b] = 1'b0;
        end

        // Receive mirror: set wins over the software clear
        if (rx_store_done && rx_store_idx < buf_idx_t'(`FC_MIRRORED_BUFFERS))
            mirror_set[rx_store_idx[2:0]] = 1'b1;
        next_s.mirror = (s.mirror & ~new_data_clear) | mirror_set;

        // Initialization drops every pending request; a frame on the bus
        // still ends normally but its request is gone, so no retry follows
        if (init_request)
        begin
            next_s.req = '0;
            next_s.abort = '0;
            next_s.requeued = '0;
            next_s.mirror = '0;
        end

        if (frame_start_clear_control && sof_mode && rx_store_done
            && rx_store_idx == `FC_SOF_BUFFER)
            next_s.sof_enable_clear = 1'b1;

        // Receive pin: three flops, a change counts once stages two and three agree
        next_s.rx_sync = {s.rx_sync[1:0], can_rxd};
        if (s.rx_sync[1] == s.rx_sync[2])
            next_s.rx_level = s.rx_sync[2];
        if (tq_tick)
            next_s.rx_hist = {s.rx_hist[1:0], s.rx_level};
        if (sample_point)
        begin
            next_s.rx_bit_valid = 1'b1;
            if (triple_sample_select)
                next_s.rx_bit = (s.rx_hist[0] & s.rx_hist[1]) | (s.rx_hist[1] & s.rx_hist[2])
                    | (s.rx_hist[0] & s.rx_hist[2]);
            else
                next_s.rx_bit = s.rx_level;
        end

        // Listen-only gates every driving path to recessive
        next_s.can_txd = listen_only_select ? 1'b1 : proto_tx_bit;
        next_s.ack_enable = !listen_only_select;
        next_s.error_frame_enable = !listen_only_select;
        next_s.err_count_enable = !listen_only_select;

        next_s.roles = roles_of(s.filter);

        // Two-entry store queue; the source stalls on match_ready
        eligible = match_vec & ~s.roles.mask_role;
        push = match_valid && s.match_ready && eligible != '0;
        pop = s.store_valid && store_ready;
        next_s.fifo_wr = s.fifo_wr ^ push;
        next_s.fifo_rd = s.fifo_rd ^ pop;
        if (push)
            next_s.fifo_mem[s.fifo_wr] = winner(match_vec, s.roles);
        case ({push, pop})
            2'b10: next_s.fifo_count = s.fifo_count + 2'd1;
            2'b01: next_s.fifo_count = s.fifo_count - 2'd1;
            default: next_s.fifo_count = s.fifo_count;
        endcase
        next_s.match_ready = next_s.fifo_count != 2'd2;
        next_s.store_valid = next_s.fifo_count != 2'd0;
        next_s.store_idx = next_s.fifo_mem[next_s.fifo_rd];

        // Read data is captured on the read strobe and held
        if (reg_rd)
        begin
            if (reg_addr == TX_ADDR)
                next_s.reg_rdata = {s.prio, 1'b0, s.done, s.abort, s.req};
            else if (reg_addr == MES_ADDR)
                next_s.reg_rdata = s.mirror;
            else if (reg_addr == FLT_ADDR)
                next_s.reg_rdata = s.filter;
            else
                next_s.reg_rdata = `FC_UNMAPPED_READ;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s <= '0;
            s.tx_state <= TX_IDLE;
            s.rx_sync <= 3'b111; // Bus idles recessive
            s.rx_level <= 1'b1;
            s.rx_hist <= 3'b111;
            s.rx_bit <= 1'b1;
            s.can_txd <= 1'b1;
            s.match_ready <= 1'b1;
            s.filter <= `FC_ID_FILTER_CONTROL_RESET;
            s.mirror <= `FC_RX_NEW_MESSAGE_RESET;
        end
        else
            s <= next_s;
    end

    // ==========================================================
    // Outputs, all straight from the state register
    assign reg_rdata = s.reg_rdata;
    assign match_ready = s.match_ready;
    assign store_valid = s.store_valid;
    assign store_idx = s.store_idx;
    assign can_txd = s.can_txd;
    assign ack_enable = s.ack_enable;
    assign error_frame_enable = s.error_frame_enable;
    assign err_count_enable = s.err_count_enable;
    assign tx_start = s.tx_start;
    assign tx_buf = s.tx_buf;
    assign sof_enable_clear = s.sof_enable_clear;
    assign rx_bit = s.rx_bit;
    assign rx_bit_valid = s.rx_bit_valid;
    assign filter_roles = s.roles;
endmodule

`default_nettype wire

// ===== sim/can_fc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Port checks for the function control block
module can_fc_assertions (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic listen_only_select,
    input wire logic frame_start_clear_control,
    input wire logic sof_mode,
    input wire logic sample_point,
    input wire can_fc_pkg::tx_event_t tx_event,
    input wire logic rx_store_done,
    input wire can_fc_pkg::buf_idx_t rx_store_idx,
    input wire logic store_ready,
    input wire logic match_ready,
    input wire logic store_valid,
    input wire can_fc_pkg::buf_idx_t store_idx,
    input wire logic can_txd,
    input wire logic ack_enable,
    input wire logic error_frame_enable,
    input wire logic err_count_enable,
    input wire logic tx_start,
    input wire logic sof_enable_clear,
    input wire logic rx_bit_valid,
    input wire logic rx_bit
);
    import can_fc_pkg::*;
    logic slot;
    logic sof_cause;
    default clocking cb @(posedge ref_clk);
    endclocking
    logic rst_q;
    // Outputs still show reset values one edge after release, so checks wait a cycle
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rst_q <= 1'b1;
        else
            rst_q <= 1'b0;
    end
    default disable iff (sys_rst || rst_q);
    // Causes kept as plain signals so that $past sees a single net
    assign slot = tx_event.start_slot;
    assign sof_cause = rx_store_done && rx_store_idx == 4'h4 && frame_start_clear_control && sof_mode;
    property p_listen_recessive;
        listen_only_select |=> can_txd;
    endproperty
    a_listen_recessive: assert property (p_listen_recessive)
        else $error("transmit pin driven in listen-only");
    property p_reply_gates;
        1 |=> ack_enable == !$past(listen_only_select) && error_frame_enable == ack_enable;
    endproperty
    a_reply_gates: assert property (p_reply_gates)
        else $error("ack or error frame gate wrong");
    property p_count_freeze;
        1 |=> err_count_enable == !$past(listen_only_select);
    endproperty
    a_count_freeze: assert property (p_count_freeze)
        else $error("error counting gate wrong");
    property p_start_cause;
        tx_start |-> $past(slot) && !$past(listen_only_select);
    endproperty
    a_start_cause: assert property (p_start_cause)
        else $error("frame start without a start slot");
    property p_sample_valid;
        1 |=> rx_bit_valid == $past(sample_point);
    endproperty
    a_sample_valid: assert property (p_sample_valid)
        else $error("sampled bit not one cycle after sample point");
    property p_bit_update;
        $changed(rx_bit) |-> rx_bit_valid;
    endproperty
    a_bit_update: assert property (p_bit_update)
        else $error("sampled bit moved without a valid pulse");
    property p_sof_clear;
        1 |=> sof_enable_clear == $past(sof_cause);
    endproperty
    a_sof_clear: assert property (p_sof_clear)
        else $error("frame-start enable clear wrong");
    property p_store_hold;
        store_valid && !store_ready |=> store_valid && $stable(store_idx);
    endproperty
    a_store_hold: assert property (p_store_hold)
        else $error("queue head dropped while stalled");
    property p_full_keeps;
        store_valid && store_ready && !match_ready |=> store_valid;
    endproperty
    a_full_keeps: assert property (p_full_keeps)
        else $error("second queued entry lost");
    c_start: cover property (tx_start);
    c_sof: cover property (sof_enable_clear);
    c_full: cover property (store_valid && store_ready && !match_ready);
endmodule
bind can_tx_rx_function_control can_fc_assertions chk (.ref_clk, .sys_rst, .listen_only_select,
    .frame_start_clear_control, .sof_mode, .sample_point, .tx_event, .rx_store_done,
    .rx_store_idx, .store_ready, .match_ready, .store_valid, .store_idx, .can_txd, .ack_enable,
    .error_frame_enable, .err_count_enable, .tx_start, .sof_enable_clear, .rx_bit_valid,
    .rx_bit);
`default_nettype wire

// ===== sim/can_fc_node.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Far side: the protocol engine and the other nodes deciding each frame
module can_fc_node (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic tx_start,
    input wire logic [1:0] mode,
    input wire logic [3:0] delay,
    output logic ok,
    output logic arb_lost,
    output logic err
);
    logic busy;
    logic [3:0] cnt;
    // A started frame always runs its full length; an abort cannot cut it
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            {busy, cnt, ok, arb_lost, err} <= '0;
        end
        else
        begin
            {ok, arb_lost, err} <= 3'h0;
            if (tx_start)
            begin
                busy <= 1'b1;
                cnt <= delay;
            end
            else if (busy && cnt == 4'h0)
            begin
                busy <= 1'b0;
                {ok, arb_lost, err} <= {mode == 2'd0, mode == 2'd1, mode == 2'd2};
            end
            else if (busy)
                cnt <= cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== sim/can_tx_rx_function_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_fc_map.svh"
module can_tx_rx_function_control_bench;
    import can_fc_pkg::*;
    logic ref_clk, sys_rst, reg_wr, reg_rd, init_request, listen_only_select, tq_tick;
    logic triple_sample_select, frame_start_clear_control, sof_mode, can_rxd, sample_point;
    logic proto_tx_bit, rx_store_done, match_valid, store_ready, match_ready, store_valid;
    logic can_txd, ack_enable, error_frame_enable, err_count_enable, tx_start, tx_buf;
    logic sof_enable_clear, rx_bit, rx_bit_valid, slot, n_ok, n_lost, n_err, hold, rd_seen;
    logic done0;
    logic [15:0] reg_addr, match_vec;
    logic [7:0] reg_wdata, reg_rdata, new_data_clear;
    logic [3:0] dly;
    logic [1:0] mode;
    buf_idx_t rx_store_idx, store_idx;
    tx_event_t tx_event;
    filter_roles_t filter_roles;
    logic [7:0] qr[$], qs[$];
    logic qb[$];
    int errors, check_count, m;
    logic [7:0] flt [7] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h02, 8'h05, 8'h06};
    logic [15:0] vec [7] = '{16'h0003, 16'h0003, 16'h0013, 16'h0001, 16'h000c, 16'h0016, 16'h0018};
    logic [4:0] win [7] = '{5'h00, 5'h01, 5'h04, 5'h10, 5'h03, 5'h01, 5'h03};
    can_tx_rx_function_control uut (.ref_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .init_request, .listen_only_select, .triple_sample_select,
        .frame_start_clear_control, .sof_mode, .can_rxd, .tq_tick, .sample_point, .proto_tx_bit,
        .tx_event, .rx_store_done, .rx_store_idx, .new_data_clear, .match_valid, .match_vec,
        .store_ready, .match_ready, .store_valid, .store_idx, .can_txd, .ack_enable,
        .error_frame_enable, .err_count_enable, .tx_start, .tx_buf, .sof_enable_clear, .rx_bit,
        .rx_bit_valid, .filter_roles);
    can_fc_node node (.ref_clk, .sys_rst, .tx_start, .mode, .delay(dly), .ok(n_ok),
        .arb_lost(n_lost), .err(n_err));
    assign tx_event = {slot, n_ok, n_lost, n_err};
    // ========
    // Clock, comparisons, bus and event tasks
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic cmp8(string n, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp1(string n, logic e, logic g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic complete_run;
        if (errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [15:0] a, logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        qr.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    // Start slot; go says whether a frame start is due
    task automatic start(logic [1:0] md, logic b, logic go);
        int i;
        @(posedge ref_clk);
        mode <= md;
        dly <= 4'(4 + $urandom % 12);
        slot <= 1'b1;
        if (go)
            qb.push_back(b);
        @(posedge ref_clk);
        slot <= 1'b0;
        for (i = 0; i < 8 && !tx_start; i++) @(posedge ref_clk);
    endtask
    task automatic finish();
        int i;
        for (i = 0; i < 40 && !(n_ok | n_lost | n_err); i++) @(posedge ref_clk);
        @(posedge ref_clk);
    endtask
    task automatic init_pulse();
        @(posedge ref_clk);
        init_request <= 1'b1;
        @(posedge ref_clk);
        init_request <= 1'b0;
    endtask
    // Hold the match until it is taken; a winner of 5'h10 means nothing stored
    task automatic send(logic [15:0] v, logic [4:0] e);
        int i;
        @(posedge ref_clk);
        match_valid <= 1'b1;
        match_vec <= v;
        if (!e[4])
            qs.push_back({4'h0, e[3:0]});
        for (i = 0; i < 200; i++)
        begin
            @(posedge ref_clk);
            if (match_ready)
                break;
        end
        match_valid <= 1'b0;
    endtask
    task automatic drain();
        int i;
        for (i = 0; i < 200 && qs.size() > 0; i++) @(posedge ref_clk);
    endtask
    // ========
    // Results are checked against the oldest note as they appear
    always @(posedge ref_clk)
    begin
        if (rd_seen)
            cmp8("reg_rdata", qr.pop_front(), reg_rdata);
        if (tx_start && qb.size() == 0)
            cmp1("tx_start", 1'b0, tx_start);
        else if (tx_start)
            cmp1("tx_buf", qb.pop_front(), tx_buf);
        if (store_valid && store_ready && qs.size() == 0)
            cmp1("store_valid", 1'b0, store_valid);
        else if (store_valid && store_ready)
            cmp8("store_idx", qs.pop_front(), {4'h0, store_idx});
        rd_seen <= reg_rd;
    end
    // Random bit-level traffic; the receiver stalls at random and on hold
    always @(posedge ref_clk)
    begin
        {tq_tick, can_rxd, proto_tx_bit} <= 3'($urandom);
        {triple_sample_select, frame_start_clear_control, sof_mode} <= 3'($urandom);
        sample_point <= ($urandom % 4 == 0);
        store_ready <= !hold && ($urandom % 4 != 0);
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        complete_run();
    end
    // ========
    // Main sequence
    initial
    begin
        {sys_rst, reg_wr, reg_rd, init_request, listen_only_select, slot, match_valid} = 7'h40;
        {hold, rx_store_done} = 2'h0;
        {reg_addr, match_vec, reg_wdata, new_data_clear, rx_store_idx, dly, mode} = '0;
        errors = 0;
        check_count = 0;
        void'($urandom(57));
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`FC_TX_CONTROL_CH0, 8'h00);
        rd(`FC_RX_NEW_MESSAGE_CH0, 8'h00);
        rd(`FC_ID_FILTER_CONTROL_CH0, 8'h00);
        rd(`FC_TX_CONTROL_CH1, 8'h00);
        wr(`FC_TX_CONTROL_CH0, 8'h02);
        rd(`FC_TX_CONTROL_CH0, 8'h02);
        wr(`FC_TX_CONTROL_CH0, 8'h81);
        rd(`FC_TX_CONTROL_CH0, 8'h83);
        start(2'd0, 1'b1, 1'b1);
        finish();
        rd(`FC_TX_CONTROL_CH0, 8'ha1);
        start(2'd2, 1'b0, 1'b1);
        finish();
        rd(`FC_TX_CONTROL_CH0, 8'ha1);
        start(2'd0, 1'b0, 1'b1);
        finish();
        rd(`FC_TX_CONTROL_CH0, 8'hb0);
        // Abort during a frame that then succeeds, loses arbitration or fails
        done0 = 1'b1;
        for (m = 0; m < 3; m++)
        begin
            wr(`FC_TX_CONTROL_CH0, 8'h01);
            start(2'(m), 1'b0, 1'b1);
            wr(`FC_TX_CONTROL_CH0, 8'h05);
            rd(`FC_TX_CONTROL_CH0, {3'b001, done0, 4'h5});
            finish();
            done0 = (m == 0);
            rd(`FC_TX_CONTROL_CH0, {3'b001, done0, 4'h0});
        end
        listen_only_select <= 1'b1;
        wr(`FC_TX_CONTROL_CH0, 8'h03);
        start(2'd0, 1'b0, 1'b0);
        rd(`FC_TX_CONTROL_CH0, 8'h23);
        init_pulse();
        listen_only_select <= 1'b0;
        rd(`FC_TX_CONTROL_CH0, 8'h20);
        for (m = 0; m < 9; m++)
        begin
            @(posedge ref_clk);
            rx_store_done <= 1'b1;
            rx_store_idx <= 4'(m);
        end
        @(posedge ref_clk);
        rx_store_done <= 1'b0;
        rd(`FC_RX_NEW_MESSAGE_CH0, 8'hff);
        wr(`FC_RX_NEW_MESSAGE_CH0, 8'h00);
        rd(`FC_RX_NEW_MESSAGE_CH0, 8'hff);
        new_data_clear <= 8'h0f;
        @(posedge ref_clk);
        new_data_clear <= 8'h00;
        rd(`FC_RX_NEW_MESSAGE_CH0, 8'hf0);
        init_pulse();
        rd(`FC_RX_NEW_MESSAGE_CH0, 8'h00);
        // Filter set-up only while initializing
        init_request <= 1'b1;
        wr(`FC_ID_FILTER_CONTROL_CH0, 8'hff);
        rd(`FC_ID_FILTER_CONTROL_CH0, 8'hf7);
        for (m = 0; m < 7; m++)
        begin
            wr(`FC_ID_FILTER_CONTROL_CH0, flt[m]);
            repeat (2) @(posedge ref_clk);
            cmp8("mask_role", {5'h00, flt[m][1], 1'b0, flt[m][0]},
                filter_roles.mask_role[7:0]);
            send(vec[m], win[m]);
            drain();
        end
        wr(`FC_ID_FILTER_CONTROL_CH0, 8'h00);
        init_request <= 1'b0;
        hold <= 1'b1;
        send(16'h0020, 5'h05);
        send(16'h0040, 5'h06);
        repeat (3) @(posedge ref_clk);
        cmp1("match_ready", 1'b0, match_ready);
        hold <= 1'b0;
        send(16'h8000, 5'h0f);
        drain();
        complete_run();
    end
endmodule
`default_nettype wire
